// ---- hw/deframer_ctrl_pkg.sv ----
// Purpose: shared constants and types for the deframer control block
// Assumes: registers sit on one aligned 32-bit word each, byte address = 4 * index
// Notes: only the low byte of each word carries data; upper bits read as zero
package deframer_ctrl_pkg;

  // bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;

  // register indexes; the byte address is the index shifted left by two
  localparam logic [IDX_W-1:0] IDX_CTRL_ZERO = 12'h475;
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE = 12'h476;
  localparam logic [IDX_W-1:0] IDX_CTRL_TWO = 12'h477;
  localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 12'h479;

  // deframer_control_zero fields
  localparam int BIT_RECEIVER_DISABLE = 7;
  localparam int BIT_END_CHAR_SUBST_OFF = 6;
  localparam int BIT_SYNC_RESET = 3;
  localparam int BIT_FORCED_RESYNC = 2;
  localparam int BIT_BAD_FRAME_SUBST_ON = 0;
  // deframer_control_one fields
  localparam int BIT_DISPARITY_QUALIFY = 4;
  localparam int BIT_DESCRAMBLER_START = 3;
  localparam int BIT_POST_SYNC_SELECT = 2;
  localparam int BIT_SKIP_ALIGNMENT = 1;
  localparam int BIT_CHECKSUM_METHOD = 0;
  // deframer_control_two fields
  localparam int BIT_LINK_TEST_MODE = 7;
  localparam int BIT_REPEAT_PATTERN = 5;

  // reset values and writable-bit masks
  localparam logic [7:0] CTRL_ZERO_RST = 8'h01;
  localparam logic [7:0] CTRL_ONE_RST = 8'h14;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] CTRL_ZERO_MASK = 8'hcd;
  localparam logic [7:0] CTRL_ONE_MASK = 8'h1f;
  localparam logic [7:0] CTRL_TWO_MASK = 8'ha0;

  // descrambler start octet choices
  localparam logic [1:0] OCTET_FIRST = 2'h0;
  localparam logic [1:0] OCTET_THIRD = 2'h2;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;

  // link phase, one-hot
  typedef enum logic [2:0] {
    PH_CGS = 3'b001,
    PH_ILAS = 3'b010,
    PH_DATA = 3'b100
  } link_phase_e;

  // one decoded character per cycle plus link events from the lane
  typedef struct packed {
    logic valid;             // character present this cycle
    logic is_k;              // character is /K/
    logic is_r;              // character is /R/
    logic nit_err;           // not-in-table error on this character
    logic rd_err;            // running disparity error on this character
    logic end_of_frame;      // frame-end position, candidate for /F/
    logic end_of_multiframe; // multiframe-end position, candidate for /A/
    logic frame_err;         // frame received with errors
    logic cgs_achieved;      // code group sync reached
    logic ilas_done;         // alignment sequence finished
    logic disparity_limit;   // enough disparity errors counted
  } lane_char_s;

  // steering toward the lane datapath
  typedef struct packed {
    logic run;               // deframer active
    logic rd_err_report;     // qualified disparity error
    logic nit_err_report;    // not-in-table error
    logic substitute_end;    // replace end character now
    logic replace_frame;     // replace the errored frame
    logic [1:0] descramble_octet; // first descrambled octet
    logic checksum_method;   // checksum method select
    logic repeat_pattern_check; // repetitive pattern check on
    logic expect_ilas_forever; // test mode expectation
  } datapath_ctrl_s;

endpackage

// ---- hw/serial_link_deframer_control.sv ----
// Purpose: control logic for a serial link receive deframer
// Assumes: single clock; lane characters arrive decoded, one per cycle
// Notes: registers reached over avalon-mm, one wait state per access
`timescale 1ns/1ps
// register map, one 8-bit register in the low byte of each 32-bit word:
//   byte 0x11d4 deframer_control_zero: 7 receiver off, 6 end subst off, 3 sync reset,
//     2 forced resync, 0 bad frame subst on
//   byte 0x11d8 deframer_control_one: 4 disparity qualify, 3 descrambler start,
//     2 post-sync select, 1 skip alignment, 0 checksum method
//   byte 0x11dc deframer_control_two: 7 link test mode, 5 repeat pattern test
//   byte 0x11e4 link status, read only: 3 resync request, 2:0 phase one-hot
// any other or misaligned address answers with a decode error and reads zero
module serial_link_deframer_control (
  input wire logic clock, // 100 MHz system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [deframer_ctrl_pkg::ADDR_W-1:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [deframer_ctrl_pkg::DATA_W-1:0] writedata, // write data
  input wire logic [3:0] byteenable, // byte lanes
  output logic [deframer_ctrl_pkg::DATA_W-1:0] readdata, // read data
  output logic [1:0] response, // okay or decode error
  output logic waitrequest, // stall while not done
  input wire deframer_ctrl_pkg::lane_char_s lane_char, // decoded lane input
  output deframer_ctrl_pkg::datapath_ctrl_s datapath_ctrl, // datapath steering
  output logic resync_request_output // sync request toward transmitter
);

  // register index of a byte address, or all ones when misaligned
  // shared by the read decode and the write decode
  function automatic logic [deframer_ctrl_pkg::IDX_W-1:0] reg_index(
      input logic [deframer_ctrl_pkg::ADDR_W-1:0] addr);
    logic [deframer_ctrl_pkg::IDX_W-1:0] idx;
    idx = addr[deframer_ctrl_pkg::ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      idx = '1;
    end
    return idx;
  endfunction

  // true when the index names a mapped register
  // the status word is mapped but read only
  function automatic logic is_mapped(input logic [deframer_ctrl_pkg::IDX_W-1:0] idx);
    return (idx == deframer_ctrl_pkg::IDX_CTRL_ZERO) ||
           (idx == deframer_ctrl_pkg::IDX_CTRL_ONE) ||
           (idx == deframer_ctrl_pkg::IDX_CTRL_TWO) ||
           (idx == deframer_ctrl_pkg::IDX_LINK_STATUS);
  endfunction

  // register state and next values
  logic [deframer_ctrl_pkg::IDX_W-1:0] idx;
  logic [7:0] ctrl_zero_r, ctrl_zero_nxt;
  logic [7:0] ctrl_one_r, ctrl_one_nxt;
  logic [7:0] ctrl_two_r, ctrl_two_nxt;
  logic ack_r, ack_nxt;
  logic [deframer_ctrl_pkg::DATA_W-1:0] readdata_r, readdata_nxt;
  logic [1:0] response_r, response_nxt;
  deframer_ctrl_pkg::link_phase_e phase_r, phase_nxt;
  logic prev_k_r, prev_k_nxt;
  logic resync_r, resync_nxt;
  deframer_ctrl_pkg::datapath_ctrl_s ctrl_r, ctrl_nxt;
  // field views and decoded strobes
  logic sync_reset;
  logic rx_off;
  logic active;
  logic resync_event;
  logic do_write;

  assign idx = reg_index(address);

  // field views of the control registers
  assign sync_reset = ctrl_zero_r[deframer_ctrl_pkg::BIT_SYNC_RESET];
  assign rx_off = ctrl_zero_r[deframer_ctrl_pkg::BIT_RECEIVER_DISABLE];
  assign active = !sync_reset && !rx_off;

  // bus handshake: one wait cycle, then completion
  // the first cycle of a request decodes and loads read data and response;
  // waitrequest then drops and a write lands on the edge that ends it
  // read data is registered, so no decode path reaches the bus directly
  always_comb begin
    ack_nxt = (read || write) && !ack_r;
    do_write = write && ack_r;
    readdata_nxt = readdata_r;
    response_nxt = response_r;
    if ((read || write) && !ack_r) begin
      response_nxt = is_mapped(idx) ? deframer_ctrl_pkg::RESP_OKAY :
                     deframer_ctrl_pkg::RESP_DECODEERROR;
      readdata_nxt = '0;
      if (read) begin
        case (idx)
          deframer_ctrl_pkg::IDX_CTRL_ZERO: begin
            readdata_nxt[7:0] = ctrl_zero_r;
          end
          deframer_ctrl_pkg::IDX_CTRL_ONE: begin
            readdata_nxt[7:0] = ctrl_one_r;
          end
          deframer_ctrl_pkg::IDX_CTRL_TWO: begin
            readdata_nxt[7:0] = ctrl_two_r;
          end
          deframer_ctrl_pkg::IDX_LINK_STATUS: begin
            readdata_nxt[7:0] = {4'h0, resync_r, phase_r};
          end
          default: begin
            readdata_nxt = '0;
          end
        endcase
      end
    end
  end

  // bus response registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      readdata_r <= '0;
      response_r <= deframer_ctrl_pkg::RESP_OKAY;
    end else begin
      ack_r <= ack_nxt;
      readdata_r <= readdata_nxt;
      response_r <= response_nxt;
    end
  end

  // handshake out combinational, data and response out of flip-flops
  assign waitrequest = (read || write) && !ack_r;
  assign readdata = readdata_r;
  assign response = response_r;

  // register writes; only writable bits take the data, reserved stay zero
  // a write with byte lane 0 off is acknowledged but stores nothing
  // the soft reset bit leaves these registers alone; only deframer state clears
  always_comb begin
    ctrl_zero_nxt = ctrl_zero_r;
    ctrl_one_nxt = ctrl_one_r;
    ctrl_two_nxt = ctrl_two_r;
    if (do_write && byteenable[0]) begin
      case (idx)
        deframer_ctrl_pkg::IDX_CTRL_ZERO: begin
          ctrl_zero_nxt = writedata[7:0] & deframer_ctrl_pkg::CTRL_ZERO_MASK;
        end
        deframer_ctrl_pkg::IDX_CTRL_ONE: begin
          ctrl_one_nxt = writedata[7:0] & deframer_ctrl_pkg::CTRL_ONE_MASK;
        end
        deframer_ctrl_pkg::IDX_CTRL_TWO: begin
          ctrl_two_nxt = writedata[7:0] & deframer_ctrl_pkg::CTRL_TWO_MASK;
        end
        default: begin
          ctrl_zero_nxt = ctrl_zero_r;
        end
      endcase
    end
  end

  // control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_zero_r <= deframer_ctrl_pkg::CTRL_ZERO_RST;
      ctrl_one_r <= deframer_ctrl_pkg::CTRL_ONE_RST;
      ctrl_two_r <= deframer_ctrl_pkg::CTRL_TWO_RST;
    end else begin
      ctrl_zero_r <= ctrl_zero_nxt;
      ctrl_one_r <= ctrl_one_nxt;
      ctrl_two_r <= ctrl_two_nxt;
    end
  end

  // resync causes once code group sync is reached
  // with post-sync select set, a /K/ followed by anything but /K/ or /R/ counts;
  // with it clear, only the lane's disparity-limit flag counts; no cause is
  // taken while the phase machine is still hunting for code group sync
  always_comb begin
    resync_event = 1'b0;
    if (active && !phase_r[0]) begin
      if (ctrl_one_r[deframer_ctrl_pkg::BIT_POST_SYNC_SELECT]) begin
        resync_event = prev_k_r && lane_char.valid &&
                       !lane_char.is_k && !lane_char.is_r;
      end else begin
        resync_event = lane_char.disparity_limit;
      end
    end
  end

  // link phase machine: sync, alignment sequence, user data
  // skip alignment wins over test mode, so a single-lane link with both set
  // goes straight to user data; test mode otherwise parks the machine in the
  // alignment phase, and any resync cause sends it back to sync hunting
  // held in sync hunting while the soft reset or receiver disable bit is set
  always_comb begin
    phase_nxt = phase_r;
    prev_k_nxt = prev_k_r;
    if (!active) begin
      phase_nxt = deframer_ctrl_pkg::PH_CGS;
      prev_k_nxt = 1'b0;
    end else begin
      if (lane_char.valid) begin
        prev_k_nxt = lane_char.is_k;
      end
      case (phase_r)
        deframer_ctrl_pkg::PH_CGS: begin
          if (lane_char.cgs_achieved) begin
            if (ctrl_one_r[deframer_ctrl_pkg::BIT_SKIP_ALIGNMENT]) begin
              phase_nxt = deframer_ctrl_pkg::PH_DATA;
            end else begin
              phase_nxt = deframer_ctrl_pkg::PH_ILAS;
            end
          end
        end
        deframer_ctrl_pkg::PH_ILAS: begin
          if (resync_event) begin
            phase_nxt = deframer_ctrl_pkg::PH_CGS;
          end else if (lane_char.ilas_done &&
                       !ctrl_two_r[deframer_ctrl_pkg::BIT_LINK_TEST_MODE]) begin
            phase_nxt = deframer_ctrl_pkg::PH_DATA;
          end
        end
        deframer_ctrl_pkg::PH_DATA: begin
          if (resync_event) begin
            phase_nxt = deframer_ctrl_pkg::PH_CGS;
          end
        end
        default: begin
          phase_nxt = deframer_ctrl_pkg::PH_CGS;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= deframer_ctrl_pkg::PH_CGS; // sync hunting after reset
      prev_k_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      prev_k_r <= prev_k_nxt;
    end
  end

  // sync request: forced by software, during sync, or on a resync cause
  // the forced bit acts even while the deframer is held, so software can
  // keep the transmitter in sync hunting across a reconfiguration
  // the output is registered to keep the pin free of decode glitches
  always_comb begin
    resync_nxt = ctrl_zero_r[deframer_ctrl_pkg::BIT_FORCED_RESYNC];
    if (active && (phase_r[0] || resync_event)) begin
      resync_nxt = 1'b1;
    end
  end

  // datapath steering, registered
  // per-character fields pulse for one cycle, one edge after the character;
  // configuration fields follow the registers as levels
  // everything per character is forced low while the deframer is held
  always_comb begin
    ctrl_nxt = '0;
    ctrl_nxt.run = active;
    if (active && lane_char.valid) begin
      ctrl_nxt.nit_err_report = lane_char.nit_err;
      ctrl_nxt.rd_err_report = lane_char.rd_err &&
          !(ctrl_one_r[deframer_ctrl_pkg::BIT_DISPARITY_QUALIFY] &&
            lane_char.nit_err);
      ctrl_nxt.substitute_end = phase_r[2] &&
          !ctrl_zero_r[deframer_ctrl_pkg::BIT_END_CHAR_SUBST_OFF] &&
          (lane_char.end_of_frame || lane_char.end_of_multiframe);
    end
    ctrl_nxt.replace_frame = active && phase_r[2] && lane_char.frame_err &&
        ctrl_zero_r[deframer_ctrl_pkg::BIT_BAD_FRAME_SUBST_ON];
    ctrl_nxt.descramble_octet = ctrl_one_r[deframer_ctrl_pkg::BIT_DESCRAMBLER_START] ?
        deframer_ctrl_pkg::OCTET_THIRD : deframer_ctrl_pkg::OCTET_FIRST;
    ctrl_nxt.checksum_method = ctrl_one_r[deframer_ctrl_pkg::BIT_CHECKSUM_METHOD];
    ctrl_nxt.expect_ilas_forever =
        ctrl_two_r[deframer_ctrl_pkg::BIT_LINK_TEST_MODE];
    // pattern check only honoured outside link-layer test mode
    ctrl_nxt.repeat_pattern_check = ctrl_two_r[deframer_ctrl_pkg::BIT_REPEAT_PATTERN] &&
        !ctrl_two_r[deframer_ctrl_pkg::BIT_LINK_TEST_MODE];
  end

  // steering and sync request registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resync_r <= 1'b0;
      ctrl_r <= '0;
    end else begin
      resync_r <= resync_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // outputs straight from flip-flops
  assign resync_request_output = resync_r;
  assign datapath_ctrl = ctrl_r;

endmodule

// ---- test/deframer_ctrl_chk.sv ----
// Purpose: port checks for the deframer control block
// Assumes: one clock, asynchronous active low reset
// Notes: per-character outputs are traced back to the lane one cycle earlier
`timescale 1ns/1ps
module deframer_ctrl_chk (
  input wire logic clock, // clock
  input wire logic rst_n, // reset, active low
  input wire logic read, // read request
  input wire logic [deframer_ctrl_pkg::DATA_W-1:0] readdata, // read data
  input wire logic [1:0] response, // response code
  input wire logic waitrequest, // stall
  input wire deframer_ctrl_pkg::lane_char_s lane_char, // lane input
  input wire deframer_ctrl_pkg::datapath_ctrl_s datapath_ctrl, // steering
  input wire logic resync_request_output // sync request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_idle_when_held: assert property (!datapath_ctrl.run |->
    !(datapath_ctrl.substitute_end || datapath_ctrl.replace_frame ||
    datapath_ctrl.rd_err_report || datapath_ctrl.nit_err_report)) else $error("output while held");
  a_subst_cause: assert property (datapath_ctrl.substitute_end |-> $past(lane_char.valid &&
    (lane_char.end_of_frame || lane_char.end_of_multiframe))) else $error("stray substitution");
  a_replace_cause: assert property (datapath_ctrl.replace_frame |->
    $past(lane_char.frame_err)) else $error("stray frame replacement");
  a_disparity_cause: assert property (datapath_ctrl.rd_err_report |->
    $past(lane_char.rd_err)) else $error("stray disparity report");
  a_nit_cause: assert property (datapath_ctrl.nit_err_report |->
    $past(lane_char.nit_err)) else $error("stray table error report");
  a_octet_legal: assert property (
    datapath_ctrl.descramble_octet == deframer_ctrl_pkg::OCTET_FIRST ||
    datapath_ctrl.descramble_octet == deframer_ctrl_pkg::OCTET_THIRD) else $error("bad octet");
  a_pattern_guard: assert property (datapath_ctrl.repeat_pattern_check |->
    !datapath_ctrl.expect_ilas_forever) else $error("pattern check in test mode");
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_decode_zero: assert property (read && !waitrequest &&
    response == deframer_ctrl_pkg::RESP_DECODEERROR |-> readdata == 32'h0)
    else $error("data on error");
endmodule
bind serial_link_deframer_control deframer_ctrl_chk u_chk (.clock(clock), .rst_n(rst_n),
  .read(read), .readdata(readdata), .response(response), .waitrequest(waitrequest),
  .lane_char(lane_char), .datapath_ctrl(datapath_ctrl),
  .resync_request_output(resync_request_output));

// ---- test/lane_tx_model.sv ----
// Purpose: lane transmitter model feeding decoded characters
// Assumes: the bench calls put and idle, one character per clock
// Notes: idle clears valid and events and inverts stale character bits
`timescale 1ns/1ps
module lane_tx_model (
  input wire logic clock, // bench clock
  output deframer_ctrl_pkg::lane_char_s lane_char // decoded lane output
);
  // nothing on the lane before the first send
  initial lane_char = '0;
  // present one character or event from the next rising edge
  task automatic put(input logic [10:0] c);
    @(posedge clock);
    lane_char <= c;
  endtask
  // no valid character, no event; old bits flipped so they never pass as fresh
  task automatic idle();
    @(posedge clock);
    lane_char <= {1'b0, ~lane_char[9:4], 4'h0};
  endtask
endmodule

// ---- test/serial_link_deframer_control_tb.sv ----
// Purpose: self-checking bench for the deframer control block
// Assumes: bus access ends when waitrequest is seen low, lane outputs one cycle after input
// Notes: lane bits valid 400 k 200 nit 080 rd 040 eof 020 ferr 008 cgs 004 ilas 002 disp 001
`timescale 1ns/1ps
module serial_link_deframer_control_tb;
  localparam logic [11:0] c0 = deframer_ctrl_pkg::IDX_CTRL_ZERO;
  localparam logic [11:0] c1 = deframer_ctrl_pkg::IDX_CTRL_ONE;
  localparam logic [11:0] c2 = deframer_ctrl_pkg::IDX_CTRL_TWO;
  localparam logic [11:0] st = deframer_ctrl_pkg::IDX_LINK_STATUS;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] address = 14'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic [1:0] response;
  logic waitrequest;
  deframer_ctrl_pkg::lane_char_s lane_char;
  deframer_ctrl_pkg::datapath_ctrl_s datapath_ctrl;
  logic resync_request_output;
  logic [31:0] rq;
  logic [1:0] rr;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  serial_link_deframer_control DUT (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .lane_char(lane_char),
    .datapath_ctrl(datapath_ctrl), .resync_request_output(resync_request_output));
  lane_tx_model ptx (.clock(clock), .lane_char(lane_char));
  // 100 MHz clock
  always #5 clock = ~clock;
  task automatic tally_and_finish();
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] idx, input logic [1:0] lo,
      input logic [7:0] d);
    @(posedge clock);
    read <= ~w;
    write <= w;
    address <= {idx, lo};
    writedata <= {24'hffffff, d};
    // waitrequest, read data and response are taken as they stand at each rising edge
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rq = readdata;
    rr = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bus(1'b1, idx, 2'h0, d);
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 2'h0, 8'h0);
    chk(rq, {24'h0, exp});
  endtask
  task automatic send(input logic [10:0] c);
    ptx.put(c);
    ptx.idle();
    @(negedge clock);
  endtask
  task automatic t_reset();
    rdc(c0, 8'h01);
    rdc(c1, 8'h14);
    rdc(c2, 8'h00);
    bus(1'b0, 12'h478, 2'h0, 8'h0);
    chk(rr, 2'h3);
    bus(1'b0, c0, 2'h1, 8'h0);
    chk(rr, 2'h3);
    chk(datapath_ctrl.run, 1'b1);
    chk(datapath_ctrl.descramble_octet, 2'h0);
    chk(datapath_ctrl.checksum_method, 1'b0);
  endtask
  task automatic t_masks();
    wr(c0, 8'hff);
    wr(c1, 8'hff);
    wr(c2, 8'hff);
    rdc(c0, 8'hcd);
    rdc(c1, 8'h1f);
    rdc(c2, 8'ha0);
    // a write with byte lane 0 off is acknowledged but must store nothing
    byteenable <= 4'he;
    wr(c1, 8'h00);
    rdc(c1, 8'h1f);
    byteenable <= 4'hf;
    chk(datapath_ctrl.run, 1'b0);
    chk(resync_request_output, 1'b1);
    chk(datapath_ctrl.descramble_octet, 2'h2);
    chk(datapath_ctrl.checksum_method, 1'b1);
    chk(datapath_ctrl.expect_ilas_forever, 1'b1);
    wr(c2, 8'h20);
    chk(datapath_ctrl.repeat_pattern_check, 1'b1);
    wr(c0, 8'h08);
    chk(resync_request_output, 1'b0);
    wr(c0, 8'h80);
    chk(datapath_ctrl.run, 1'b0);
  endtask
  // configuration changes only under soft reset, then release
  task automatic cfg(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
    wr(c0, 8'h08 | r0);
    wr(c1, r1);
    wr(c2, r2);
    wr(c0, r0);
  endtask
  task automatic t_data();
    cfg(8'h01, 8'h14, 8'h00);
    chk(resync_request_output, 1'b1);
    send(11'h004);
    rdc(st, 8'h02);
    send(11'h002);
    rdc(st, 8'h04);
    send(11'h420);
    chk(datapath_ctrl.substitute_end, 1'b1);
    send(11'h408);
    chk(datapath_ctrl.replace_frame, 1'b1);
    send(11'h4c0);
    chk(datapath_ctrl.rd_err_report, 1'b0);
    chk(datapath_ctrl.nit_err_report, 1'b1);
    send(11'h440);
    chk(datapath_ctrl.rd_err_report, 1'b1);
    ptx.put(11'h600);
    send(11'h400);
    chk(resync_request_output, 1'b1);
    rdc(st, 8'h09);
  endtask
  task automatic t_alt();
    cfg(8'h40, 8'h02, 8'h00);
    send(11'h004);
    rdc(st, 8'h04);
    send(11'h420);
    chk(datapath_ctrl.substitute_end, 1'b0);
    send(11'h408);
    chk(datapath_ctrl.replace_frame, 1'b0);
    send(11'h4c0);
    chk(datapath_ctrl.rd_err_report, 1'b1);
    ptx.put(11'h600);
    send(11'h400);
    chk(resync_request_output, 1'b0);
    send(11'h001);
    chk(resync_request_output, 1'b1);
  endtask
  task automatic t_test();
    cfg(8'h01, 8'h14, 8'h80);
    send(11'h004);
    send(11'h002);
    rdc(st, 8'h02);
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_masks();
    t_data();
    t_alt();
    t_test();
    tally_and_finish();
  end
endmodule
